// *** src/ecp_core.sv ***
// serial eeprom instruction decoder, array and id page with write protection
// What this block does
// (R1) after reset writes to status and array are disabled until enabled
// (R2) write-disable, status write and array write completion clear the enable latch
// (R3) host sends set-write-enable first; device then sets the latch to 1
// (R4) during a write cycle only status reads are accepted
// (R5) status read repeats the 8-bit status byte while selected
// (R6) status write keeps only block-protect and protect-enable bits
// (R7) status write ignored without latch or under hardware protection
// (R8) status bits keep old values until the write cycle ends
// (R9) protect-enable may fall from 1 to 0 only with protect pin high
// (R10) array read: opcode, 16-bit address, sequential bytes wrapping at the end
// (R11) array write: 64-byte pages, offset wraps, last 64 bytes kept
// (R12) protected range never written; elsewhere only with latch set
// (R13) hardware protection guards only the status register
// (R14) id page read: A10 zero, low six bits start, auto increment
// (R15) host must not read past the 64-byte id page boundary
// (R16) id page write: opcode, A10 zero address, one or more data bytes
// (R17) lock status read with A10 one returns lock flag in bit 0
// (R18) lock status byte repeats while selected
// (R19) lock: opcode, A10 one address, data byte with bit 1 set
// (R20) lock runs only if select rises right after the eighth data bit
// (R21) deselect at a byte boundary after lock starts the write cycle
// (R22) lock refused without latch, full protection, busy or already locked
// (R23) sample input on rising clock, drive output on falling, msb first
// (R24) select rise ends the frame and starts the requested operation
// (R25) during a write cycle every status bit reads as 1
// (R26) opcode bit 3 is ignored when decoding the latch commands
// (R27) unknown opcodes are ignored until the next frame
// (R28) array addressing uses the low fifteen address bits only
`timescale 1ns/1ps
`default_nettype none
module ecp_core #(
   parameter int WR_CYCLES = ecp_pkg::WR_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic wp_n,
   output logic so,
   output logic so_oe,
   output logic write_busy
);
   import ecp_pkg::*;
   localparam int CW = $clog2(WR_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0] mem [1 << MEM_AW];
   logic [7:0] id_mem [PAGE_BYTES];
   logic [7:0] pbuf [PAGE_BYTES];

   // link domain state
   ecp_lstate_t lst_r;
   ecp_cmd_t cmd_r;
   logic [2:0] bit_cnt_r;
   logic hdr_r;
   logic [7:0] sh_r;
   logic [15:0] addr_r;
   logic [7:0] tx_r;
   logic [PAGE_AW-1:0] pofs_r;
   logic [PAGE_BYTES-1:0] pvalid_r;
   logic [6:0] nbytes_r;
   logic bnd_r;
   logic [7:0] dbyte_r;
   logic [MEM_AW-1:0] rd_ptr_r;
   logic [8:0] lk_sync;
   logic busy_l;

   // clk domain state
   logic [1:0] pin_sync;
   logic cs_s;
   logic wp_s;
   logic cs_q_r;
   logic wel_r;
   logic [1:0] bp_r;
   logic pe_r;
   logic lock_r;
   logic [7:0] status_r;
   ecp_cmd_t job_r;
   logic [1:0] new_bp_r;
   logic new_pe_r;
   logic [MEM_AW-PAGE_AW-1:0] wpage_r;
   logic t_busy;
   logic t_done;
   logic [CW-1:0] t_cnt;

   initial
   begin
      if (WR_CYCLES < PAGE_BYTES)
         $error("ecp_core: WR_CYCLES must be at least one page");
   end

   ////////////////////////////////////////////////////////////////////////
   // link side decode helpers
   wire [7:0] sh_nxt = {sh_r[6:0], si};  // msb first (R23)
   wire [15:0] addr_nxt = {addr_r[14:0], si};
   wire byte_end = (bit_cnt_r == 3'd7);
   wire hdr_end = (lst_r == LS_ADDR) && byte_end && hdr_r;

   function automatic ecp_cmd_t f_decode(input logic [7:0] op);
      // bit 3 is don't care for every opcode (R26)
      case (op & OP_MASK)
         OP_SET_WRITE_ENABLE_CMD: f_decode = CMD_SET_WRITE_ENABLE_CMD;
         OP_CLEAR_WRITE_ENABLE_CMD: f_decode = CMD_CLEAR_WRITE_ENABLE_CMD;
         OP_STATUS_READ_CMD: f_decode = CMD_STATUS_READ_CMD;
         OP_STATUS_WRITE_CMD: f_decode = CMD_STATUS_WRITE_CMD;
         OP_READ: f_decode = CMD_READ;
         OP_WRITE: f_decode = CMD_WRITE;
         OP_RDID: f_decode = CMD_RDID;
         OP_WRID: f_decode = CMD_WRID;
         default: f_decode = CMD_NONE;  // (R27)
      endcase
   endfunction

   wire ecp_cmd_t op_cmd = f_decode(sh_nxt);
   // while busy anything but a status read is dropped (R4)
   wire ecp_cmd_t op_ok = (busy_l && op_cmd != CMD_STATUS_READ_CMD) ? CMD_NONE : op_cmd;
   // A10 turns id read/write into lock status/lock (R14) (R17)
   wire ecp_cmd_t hdr_cmd = !addr_nxt[ID_SEL_BIT] ? cmd_r :
                            (cmd_r == CMD_RDID) ? CMD_RDLS :
                            (cmd_r == CMD_WRID) ? CMD_LOCK : cmd_r;

   // next byte to shift out; arrays are stable while reads are allowed
   function automatic logic [7:0] f_byte(input ecp_cmd_t c, input logic [MEM_AW-1:0] p);
      case (c)
         CMD_STATUS_READ_CMD: f_byte = lk_sync[7:0];  // (R5)
         CMD_READ: f_byte = mem[p];  // (R28)
         CMD_RDID: f_byte = id_mem[p[PAGE_AW-1:0]];  // (R14)
         CMD_RDLS: f_byte = {7'h00, lk_sync[8]};  // (R17)
         default: f_byte = 8'hFF;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // link sequencer; select high holds it idle and ends every frame
   always_ff @(posedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         lst_r <= LS_OP;
         bit_cnt_r <= 3'd0;
         hdr_r <= 1'b0;
      end
      else
      begin
         bit_cnt_r <= bit_cnt_r + 3'd1;
         case (lst_r)
            LS_OP:
               if (byte_end)
               begin
                  case (op_ok)  // (R4)
                     CMD_STATUS_READ_CMD: lst_r <= LS_DOUT;
                     CMD_STATUS_WRITE_CMD: lst_r <= LS_DIN;
                     CMD_READ, CMD_WRITE, CMD_RDID, CMD_WRID: lst_r <= LS_ADDR;
                     default: lst_r <= LS_IGNORE;  // (R27)
                  endcase
               end
            LS_ADDR:
               if (byte_end)
               begin
                  hdr_r <= 1'b1;
                  if (hdr_r)
                     lst_r <= (hdr_cmd == CMD_READ || hdr_cmd == CMD_RDID ||
                               hdr_cmd == CMD_RDLS) ? LS_DOUT : LS_DIN;
               end
            default: lst_r <= lst_r;
         endcase
      end
   end

   // command, address and header capture; no reset, rebuilt every frame
   always_ff @(posedge sck)
   begin
      sh_r <= sh_nxt;
      bnd_r <= (lst_r == LS_DIN) && byte_end;  // byte boundary seen (R20)
      if (lst_r == LS_OP && byte_end)
         cmd_r <= op_ok;
      else if (hdr_end)
         cmd_r <= hdr_cmd;
      if (lst_r == LS_ADDR)
         addr_r <= addr_nxt;
      if (lst_r == LS_OP)
         nbytes_r <= 7'd0;
      else if (lst_r == LS_DIN && byte_end && nbytes_r != 7'h7F)
         nbytes_r <= nbytes_r + 7'd1;
      if (lst_r == LS_DIN && byte_end && nbytes_r == 7'd0)
         dbyte_r <= sh_nxt;  // first data byte feeds status write and lock
   end

   // page buffer; offset wraps so only the last 64 bytes survive (R11)
   always_ff @(posedge sck)
   begin
      if (hdr_end)
         pofs_r <= addr_nxt[PAGE_AW-1:0];
      else if (lst_r == LS_DIN && byte_end)
         pofs_r <= pofs_r + 1'b1;
      if (lst_r == LS_DIN && byte_end)
      begin
         pbuf[pofs_r] <= sh_nxt;
         // first byte wipes stale marks; done only when not busy
         if (nbytes_r == 7'd0)
            pvalid_r <= PAGE_BYTES'(1) << pofs_r;
         else
            pvalid_r[pofs_r] <= 1'b1;
      end
   end

   // transmit shifter: reload at opcode end, address end and each output byte end, else shift (R10)
   always_ff @(posedge sck)
   begin
      if (lst_r == LS_OP && byte_end)
         tx_r <= f_byte(CMD_STATUS_READ_CMD, '0);
      else if (hdr_end)
      begin
         tx_r <= f_byte(hdr_cmd, addr_nxt[MEM_AW-1:0]);
         rd_ptr_r <= addr_nxt[MEM_AW-1:0];  // A15 dropped (R28)
      end
      else if (lst_r == LS_DOUT && byte_end)
      begin
         // array pointer wraps at the top; id host stays in page (R15)
         tx_r <= f_byte(cmd_r, rd_ptr_r + 1'b1);  // (R18)
         rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      else
         tx_r <= {tx_r[6:0], 1'b0};
   end

   // output driven on falling edges (R23)
   always_ff @(negedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         so <= 1'b0;
         so_oe <= 1'b0;
      end
      else
      begin
         so <= tx_r[7];
         so_oe <= (lst_r == LS_DOUT);
      end
   end

   // status and lock flag brought into the link domain
   ecp_sync #(.W(9)) u_lk_sync (
      .clk(sck),
      .d({lock_r, status_r}),
      .q(lk_sync)
   );
   assign busy_l = lk_sync[SR_RDY_N];

   ////////////////////////////////////////////////////////////////////////
   // clk domain: frame end detection and commit
   ecp_sync #(.W(2)) u_pin_sync (
      .clk(clk),
      .d({cs_n, wp_n}),
      .q(pin_sync)
   );
   assign cs_s = pin_sync[1];
   assign wp_s = pin_sync[0];

   // link registers are frozen once select is high, so read them here
   wire frame_end = cs_s && !cs_q_r;  // (R24)
   wire hwp = pe_r && !wp_s;  // hardware protection, status only (R13)
   wire data_ok = bnd_r && nbytes_r != 7'd0;
   wire go_status_write_cmd = frame_end && cmd_r == CMD_STATUS_WRITE_CMD && data_ok && wel_r && !hwp;  // (R7)
   wire go_write = frame_end && cmd_r == CMD_WRITE && data_ok && wel_r;  // (R12)
   wire go_wrid = frame_end && cmd_r == CMD_WRID && data_ok && wel_r && !lock_r;  // (R16)
   wire go_lock = frame_end && cmd_r == CMD_LOCK && bnd_r && nbytes_r == 7'd1 &&
                  wel_r && bp_r != BP_ALL && !lock_r && dbyte_r[LOCK_DATA_BIT];  // (R20) (R22)
   wire go = (go_status_write_cmd || go_write || go_wrid || go_lock) && !t_busy;  // (R21)

   always_ff @(posedge clk)
   begin
      if (srst)
         cs_q_r <= 1'b1;
      else
         cs_q_r <= cs_s;
   end

   ecp_wr_timer #(.CYC(WR_CYCLES), .CW(CW)) u_timer (
      .clk(clk),
      .srst(srst),
      .start(go),
      .busy(t_busy),
      .cnt(t_cnt),
      .done(t_done)
   );
   assign write_busy = t_busy;

   // job capture; protect enable may only drop with pin high (R9)
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         job_r <= CMD_NONE;
         new_bp_r <= BP_RST;
         new_pe_r <= PE_RST;
         wpage_r <= '0;
      end
      else if (go)
      begin
         job_r <= cmd_r;
         new_bp_r <= {dbyte_r[SR_BP_HI], dbyte_r[SR_BP_LO]};  // (R6)
         new_pe_r <= (pe_r && !wp_s) ? 1'b1 : dbyte_r[SR_PE];  // (R9)
         wpage_r <= addr_r[MEM_AW-1:PAGE_AW];  // (R11)
      end
   end

   // write enable latch (R1) (R2) (R3)
   always_ff @(posedge clk)
   begin
      if (srst)
         wel_r <= WEL_RST;  // (R1)
      else if (t_done)
         wel_r <= 1'b0;  // (R2)
      else if (frame_end && !t_busy && cmd_r == CMD_SET_WRITE_ENABLE_CMD)
         wel_r <= 1'b1;  // (R3)
      else if (frame_end && !t_busy && cmd_r == CMD_CLEAR_WRITE_ENABLE_CMD)
         wel_r <= 1'b0;  // (R2)
   end

   // protect fields and lock change only at the end of the cycle (R8)
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         bp_r <= BP_RST;
         pe_r <= PE_RST;
         lock_r <= LOCK_RST;
      end
      else if (t_done)
      begin
         if (job_r == CMD_STATUS_WRITE_CMD)
         begin
            bp_r <= new_bp_r;  // (R8)
            pe_r <= new_pe_r;
         end
         if (job_r == CMD_LOCK)
            lock_r <= 1'b1;  // (R21)
      end
   end

   // status byte, all ones while a cycle runs (R25)
   always_ff @(posedge clk)
   begin
      if (srst)
         status_r <= 8'h00;
      else if (t_busy || go)
         status_r <= SR_BUSY_VAL;  // (R25)
      else
         status_r <= {pe_r, 3'h0, bp_r[1], bp_r[0], wel_r, 1'b0};
   end

   // copy one marked byte per cycle at the start of the write cycle
   wire [PAGE_AW-1:0] slot = t_cnt[PAGE_AW-1:0];
   wire slot_on = t_busy && t_cnt < CW'(PAGE_BYTES) && pvalid_r[slot];
   wire [MEM_AW-1:0] slot_addr = {wpage_r, slot};
   wire slot_prot = (bp_r == BP_ALL) ||
                    (bp_r == BP_HALF && slot_addr >= BP_HALF_BASE) ||
                    (bp_r == BP_QUARTER && slot_addr >= BP_QUARTER_BASE);

   always_ff @(posedge clk)
   begin
      if (slot_on && job_r == CMD_WRITE && !slot_prot)
         mem[slot_addr] <= pbuf[slot];  // (R12)
      if (slot_on && job_r == CMD_WRID)
         id_mem[slot] <= pbuf[slot];  // (R16)
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_lock_commit;
      frame_end && cmd_r == CMD_LOCK && !t_busy;
   endsequence

   a_wel_set: assert property (@(posedge clk) disable iff (srst)
      frame_end && !t_busy && cmd_r == CMD_SET_WRITE_ENABLE_CMD |=> wel_r)  // (R3)
      else $error("write enable latch not set");

   a_wel_done: assert property (@(posedge clk) disable iff (srst)
      t_done |=> !wel_r)  // (R2)
      else $error("write enable latch not cleared after write");

   a_busy_status: assert property (@(posedge clk) disable iff (srst)
      t_busy ##1 t_busy |-> status_r == SR_BUSY_VAL)  // (R25)
      else $error("status not all ones while busy");

   a_status_write_cmd_gate: assert property (@(posedge clk) disable iff (srst)
      frame_end && cmd_r == CMD_STATUS_WRITE_CMD && (!wel_r || hwp) && !t_busy |=> !t_busy)  // (R7)
      else $error("status write accepted while blocked");

   a_sr_hold: assert property (@(posedge clk) disable iff (srst)
      t_busy && !t_done |=> $stable(bp_r) && $stable(pe_r))  // (R8)
      else $error("status bits changed before cycle end");

   a_pe_drop: assert property (@(posedge clk) disable iff (srst)
      $fell(pe_r) |-> $past(wp_s, 2) || $past(wp_s, 1))  // (R9)
      else $error("protect enable cleared with pin low");

   a_lock_refuse: assert property (@(posedge clk) disable iff (srst)
      s_lock_commit ##0 (bp_r == BP_ALL || !wel_r || lock_r) |=> !t_busy)  // (R22)
      else $error("lock accepted while refused");

   a_lock_start: assert property (@(posedge clk) disable iff (srst)
      s_lock_commit ##0 (go_lock && !t_busy) |=> t_busy ##[1:2] status_r == SR_BUSY_VAL)  // (R21)
      else $error("lock did not start a write cycle");

   a_busy_reject: assert property (@(posedge sck) disable iff (cs_n)
      lst_r == LS_OP && byte_end && busy_l && op_cmd != CMD_STATUS_READ_CMD |=> lst_r == LS_IGNORE)  // (R4)
      else $error("command taken during write cycle");

   a_sr_repeat: assert property (@(posedge sck) disable iff (cs_n)
      lst_r == LS_DOUT && cmd_r == CMD_STATUS_READ_CMD && byte_end |=> tx_r == lk_sync[7:0] ||
      $changed(lk_sync))  // (R5)
      else $error("status byte not repeated");

endmodule // ecp_core
`default_nettype wire

// *** src/ecp_pkg.sv ***
// shared constants and types for the serial eeprom command and protect block
package ecp_pkg;
   localparam int MEM_AW = 15;
   localparam int PAGE_AW = 6;
   localparam int PAGE_BYTES = 64;
   localparam int ID_SEL_BIT = 10;
   localparam int LOCK_DATA_BIT = 1;
   localparam logic [7:0] OP_MASK = 8'hF7;
   localparam logic [7:0] OP_SET_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] OP_CLEAR_WRITE_ENABLE_CMD = 8'h04;
   localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_RDID = 8'h83;
   localparam logic [7:0] OP_WRID = 8'h82;
   // status byte layout
   localparam int SR_RDY_N = 0;
   localparam int SR_WEL = 1;
   localparam int SR_BP_LO = 2;
   localparam int SR_BP_HI = 3;
   localparam int SR_PE = 7;
   localparam logic [7:0] SR_BUSY_VAL = 8'hFF;
   localparam logic [1:0] BP_ALL = 2'h3;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [14:0] BP_QUARTER_BASE = 15'h6000;
   localparam logic [14:0] BP_HALF_BASE = 15'h4000;
   // reset values
   localparam logic WEL_RST = 1'b0;
   localparam logic [1:0] BP_RST = 2'h0;
   localparam logic PE_RST = 1'b0;
   localparam logic LOCK_RST = 1'b0;
   // self-timed write length in clk cycles
   localparam int WR_CYCLES_DEF = 2000;
   typedef enum logic [3:0] {
      CMD_NONE, CMD_SET_WRITE_ENABLE_CMD, CMD_CLEAR_WRITE_ENABLE_CMD, CMD_STATUS_READ_CMD, CMD_STATUS_WRITE_CMD, CMD_READ,
      CMD_WRITE, CMD_RDID, CMD_WRID, CMD_RDLS, CMD_LOCK
   } ecp_cmd_t;
   typedef enum logic [2:0] {LS_OP, LS_ADDR, LS_DIN, LS_DOUT, LS_IGNORE} ecp_lstate_t;
endpackage

// *** src/ecp_sync.sv ***
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ecp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   // first stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      meta_r <= d;
      q <= meta_r;
   end
endmodule // ecp_sync
`default_nettype wire

// *** src/ecp_wr_timer.sv ***
// self-timed write cycle counter
`timescale 1ns/1ps
`default_nettype none
module ecp_wr_timer #(
   parameter int CYC = 2000,
   parameter int CW = 11
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   output logic busy,
   output logic [CW-1:0] cnt,
   output logic done
);
   initial
   begin
      if (CYC < 64 || CYC >= (1 << CW))
         $error("ecp_wr_timer: CYC must cover a page and fit CW");
   end
   // busy runs CYC cycles, done pulses on the same edge that busy falls
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         busy <= 1'b0;
         cnt <= '0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            busy <= 1'b1;
            cnt <= '0;
         end
         else if (busy)
         begin
            cnt <= cnt + 1'b1;
            if (cnt == CW'(CYC - 1))
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule // ecp_wr_timer
`default_nettype wire

// *** verif/ecp_host.sv ***
// spi host model that frames opcodes, addresses and data for the eeprom block
`timescale 1ns/1ps
`default_nettype none
module ecp_host (
   output var logic cs_n,
   output var logic sck,
   output var logic si,
   input wire logic so,
   input wire logic so_oe
);
   logic [7:0] txq[$];
   logic [7:0] rxq[$];
   logic oe_seen;
   logic flip;
   logic [7:0] r;
   ////////////////////////////////////////////////////////////////////////////////
   // idle bus: deselected, link clock parked low
   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      flip = 1'b0;
      oe_seen = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one mode 0 frame; xbits adds a partial byte to spoil the byte boundary
   task automatic run(input int xbits);
      rxq.delete();
      oe_seen = 1'b0;
      cs_n = 1'b0;
      for (int i = 0; i <= txq.size(); i++)
      begin
         for (int j = 7; j >= 0; j--)
         begin
            if (i == txq.size() && 7 - j >= xbits)
               break;
            si = (i < txq.size()) ? txq[i][j] : 1'b1;
            #62.5;
            sck = 1'b1;
            // undriven so must not look like data, so feed a toggling level
            flip = ~flip;
            oe_seen = oe_seen | so_oe;
            r = {r[6:0], so_oe ? so : flip};
            #62.5;
            sck = 1'b0;
         end
         if (i < txq.size())
            rxq.push_back(r);
      end
      #30;
      cs_n = 1'b1;
      si = ~si;
      #100;
   endtask
endmodule // ecp_host
`default_nettype wire

// *** verif/spi_eeprom_command_protect_tb.sv ***
// self-checking bench for the serial eeprom command and protect block
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_command_protect_tb;
   import ecp_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wp_n = 1'b1;
   wire cs_n, sck, si, so, so_oe, write_busy;
   int err_count = 0;
   int check_count = 0;
   int seed = 47;
   logic [7:0] mem [int];
   logic [7:0] idp [0:63];
   always #5 clk = ~clk;
   // long write cycle so a status poll still lands inside it
   ecp_core #(.WR_CYCLES(600)) DUT (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n),
      .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .write_busy(write_busy));
   ecp_host host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (err_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask
   // bounded wait for a running write cycle to finish
   task automatic wait_idle();
      int n;
      n = 0;
      while (write_busy !== 1'b0 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 1000)
      begin
         $display("ERROR %0t: write cycle never ended", $time);
         err_count++;
         final_report();
      end
   endtask
   task automatic xfer(input int xbits);
      host.run(xbits);
      wait_idle();
   endtask
   task automatic cmd(input logic [7:0] op);
      host.txq = '{op};
      xfer(0);
   endtask
   task automatic status_read_cmd(input logic [7:0] exp, input logic [7:0] m);
      host.txq = '{OP_STATUS_READ_CMD, 8'h00, 8'h00};
      host.run(0);
      chk(host.rxq[1] & m, exp);
      chk(host.rxq[2] & m, exp);
   endtask
   task automatic status_write_cmd(input logic [7:0] d);
      cmd(OP_SET_WRITE_ENABLE_CMD);
      host.txq = '{OP_STATUS_WRITE_CMD, d};
      xfer(0);
   endtask
   task automatic pwrite(input logic [15:0] a, input int n, input bit keep);
      logic [7:0] d;
      cmd(OP_SET_WRITE_ENABLE_CMD);
      host.txq = '{OP_WRITE, a[15:8], a[7:0]};
      for (int i = 0; i < n; i++)
      begin
         d = 8'($random(seed));
         host.txq.push_back(d);
         if (keep)
            mem[{a[14:6], 6'(int'(a[5:0]) + i)}] = d;
      end
      xfer(0);
   endtask
   task automatic pread(input logic [15:0] a, input int n);
      host.txq = '{OP_READ, a[15:8], a[7:0]};
      repeat (n)
         host.txq.push_back(8'h00);
      host.run(0);
      for (int i = 0; i < n; i++)
         chk(host.rxq[3 + i], mem[(int'(a[14:0]) + i) % 32768]);
   endtask
   task automatic lock(input int xbits, input logic [7:0] eb, input logic [7:0] el);
      host.txq = '{OP_WRID, 8'h04, 8'h00, 8'($random(seed)) | 8'h02};
      host.run(xbits);
      chk({7'h0, write_busy}, eb);
      wait_idle();
      host.txq = '{OP_RDID, 8'h04, 8'h00, 8'h00, 8'h00};
      host.run(0);
      chk(host.rxq[3] & 8'h01, el);
      chk(host.rxq[4] & 8'h01, el);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: latch, array, protection, id page
   initial
   begin
      logic [15:0] base;
      logic [5:0] off;
      logic [7:0] d;
      logic [7:0] hi;
      repeat (6) @(negedge clk);
      srst = 1'b0;
      repeat (5) @(negedge clk);
      #3.3;
      status_read_cmd(8'h00, 8'hFF);
      host.txq = '{OP_WRITE, 8'h00, 8'h10, 8'h5A};
      host.run(0);
      chk({7'h0, write_busy}, 8'h00);
      for (int x = 0; x < 2; x++)
      begin
         cmd(OP_SET_WRITE_ENABLE_CMD | 8'(x << 3));
         status_read_cmd(8'h02, 8'hFF);
         cmd(8'hA5);
         status_read_cmd(8'h02, 8'hFF);
         cmd(OP_CLEAR_WRITE_ENABLE_CMD | 8'(x << 3));
         status_read_cmd(8'h00, 8'hFF);
      end
      off = 6'($random(seed));
      pwrite(16'h8000 | 16'(off), 70, 1);
      pwrite(16'h7FC0 | 16'(off), 64, 1);
      pwrite(16'h6000, 64, 1);
      pwrite(16'h4000, 64, 1);
      pread(16'h7FFE, 4);
      pread(16'h8000, 64);
      // poll status and try a read while the write cycle runs
      cmd(OP_SET_WRITE_ENABLE_CMD);
      host.txq = '{OP_WRITE, 8'h20, 8'h00, 8'h11};
      host.run(0);
      mem[32'h2000] = 8'h11;
      status_read_cmd(8'hFF, 8'hFF);
      host.txq = '{OP_READ, 8'h20, 8'h00, 8'h00};
      host.run(0);
      chk({7'h0, host.oe_seen}, 8'h00);
      wait_idle();
      status_read_cmd(8'h00, 8'hFF);
      pread(16'h2000, 1);
      for (int bp = 1; bp < 4; bp++)
      begin
         base = (bp == 1) ? 16'h6000 : (bp == 2) ? 16'h4000 : 16'h0000;
         status_write_cmd(8'(bp << 2) | 8'h70);
         status_read_cmd(8'(bp << 2), 8'hFF);
         pwrite(base, 4, 0);
         if (bp < 3)
            pwrite(base - 16'h0004, 4, 1);
         pread(base - 16'h0004, 8);
      end
      cmd(OP_SET_WRITE_ENABLE_CMD);
      lock(0, 8'h00, 8'h00);
      status_write_cmd(8'h84);
      @(negedge clk);
      wp_n = 1'b0;
      repeat (4) @(negedge clk);
      status_write_cmd(8'h00);
      status_read_cmd(8'h84, 8'hFD);
      pwrite(16'h1000, 2, 1);
      pread(16'h1000, 2);
      @(negedge clk);
      wp_n = 1'b1;
      repeat (4) @(negedge clk);
      status_write_cmd(8'h00);
      status_read_cmd(8'h00, 8'hFF);
      // id page: don't-care address bits randomised, A10 kept low
      hi = 8'($random(seed)) & 8'hFB;
      cmd(OP_SET_WRITE_ENABLE_CMD);
      host.txq = '{OP_WRID, hi, 8'($random(seed)) & 8'hC0 | 8'(off)};
      for (int i = off; i < 64; i++)
      begin
         d = 8'($random(seed));
         host.txq.push_back(d);
         idp[i] = d;
      end
      xfer(0);
      host.txq = '{OP_RDID, hi, 8'(off)};
      repeat (64 - off)
         host.txq.push_back(8'h00);
      host.run(0);
      for (int i = off; i < 64; i++)
         chk(host.rxq[3 + i - off], idp[i]);
      cmd(OP_CLEAR_WRITE_ENABLE_CMD);
      lock(0, 8'h00, 8'h00);
      cmd(OP_SET_WRITE_ENABLE_CMD);
      lock(3, 8'h00, 8'h00);
      cmd(OP_SET_WRITE_ENABLE_CMD);
      lock(0, 8'h01, 8'h01);
      cmd(OP_SET_WRITE_ENABLE_CMD);
      lock(0, 8'h00, 8'h01);
      final_report();
   end
endmodule // spi_eeprom_command_protect_tb
`default_nettype wire
